//--- rtl/bsio_pkg.sv
// Package: register map, reset values and carrier types for the bus-shared ports
package bsio_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned BSIO_AW = 32;
  localparam int unsigned BSIO_DW = 8;
  localparam int unsigned BSIO_XW = 24;
  localparam int unsigned BSIO_XD = 16;

  // ==========================================================================
  // Register byte addresses
  localparam logic [BSIO_AW-1:0] BSIO_PORT_ZERO_DATA_ADDR        = 32'hFFFFF000;
  localparam logic [BSIO_AW-1:0] BSIO_PORT_ONE_DATA_ADDR         = 32'hFFFFF001;
  localparam logic [BSIO_AW-1:0] BSIO_PORT_ZERO_DIRECTION_ADDR   = 32'hFFFFF002;
  localparam logic [BSIO_AW-1:0] BSIO_PORT_ONE_DIRECTION_ADDR    = 32'hFFFFF004;
  localparam logic [BSIO_AW-1:0] BSIO_PORT_ONE_FUNCTION_ADDR     = 32'hFFFFF005;
  localparam logic [BSIO_AW-1:0] BSIO_PORT_TWO_DATA_ADDR         = 32'hFFFFF012;
  localparam logic [BSIO_AW-1:0] BSIO_PORT_TWO_DIRECTION_ADDR    = 32'hFFFFF014;
  localparam logic [BSIO_AW-1:0] BSIO_PORT_TWO_FUNCTION_ADDR     = 32'hFFFFF015;

  // ==========================================================================
  // Values after reset
  localparam logic [BSIO_DW-1:0] BSIO_PORT_ZERO_LATCH_RST = 8'h00;
  localparam logic [BSIO_DW-1:0] BSIO_PORT_ONE_LATCH_RST  = 8'h00;
  localparam logic [BSIO_DW-1:0] BSIO_PORT_TWO_LATCH_RST  = 8'hFF;
  localparam logic [BSIO_DW-1:0] BSIO_DIRECTION_RST       = 8'h00;
  localparam logic [BSIO_DW-1:0] BSIO_FUNCTION_RST        = 8'h00;
  localparam logic [BSIO_DW-1:0] BSIO_READ_NONE           = 8'h00;
  localparam logic [BSIO_XD-1:0] BSIO_EXT_RDATA_RST       = 16'h0000;

  // ==========================================================================
  // Address field positions on the external bus
  localparam int unsigned BSIO_MID_BYTE_LSB  = 8;
  localparam int unsigned BSIO_HIGH_BYTE_LSB = 16;

  // ==========================================================================
  // Per-pin role from function/direction pair
  typedef enum logic [1:0] {
    BSIO_ROLE_INPUT  = 2'b00,
    BSIO_ROLE_OUTPUT = 2'b01,
    BSIO_ROLE_BUS_A  = 2'b10,
    BSIO_ROLE_BUS_B  = 2'b11
  } bsio_role_e;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic              access;
    logic              addr_phase;
    logic              write;
    logic [BSIO_XW-1:0] addr;
    logic [BSIO_XD-1:0] wdata;
  } bsio_ext_bus_s;

  typedef struct packed {
    logic [BSIO_DW-1:0] out;
    logic [BSIO_DW-1:0] oe;
  } bsio_pin_drive_s;

endpackage : bsio_pkg

//--- rtl/bsio_ports.sv
// Module: three bus-shared general-purpose I/O ports with register port
`timescale 1ns/1ns
// What this block does
// - Port zero has eight pins, each with its own direction bit.
// - Reset clears every port zero direction bit so all pins start as inputs.
// - A port zero direction bit of 0 makes the pin an input and 1 an output.
// - During an external access with all port zero direction bits clear, port zero is the low muxed bus.
// - Reset clears the port zero output latch while its pins are inputs.
// - Port one has eight pins whose roles come from a direction bit and a function bit each.
// - Reset clears the port one latch, direction and function registers, leaving inputs.
// - Port one pairs select 00 input, 01 output, 10 upper muxed bus bit, 11 middle address bit.
// - Port two has eight pins whose roles come from its direction and function registers.
// - Reset sets the port two latch to all ones and clears its direction and function registers.
// - Port two pins can drive the lowest or highest external address byte.
// - Port two pairs select 00 input, 01 output, 10 lowest address bit, 11 highest address bit.
module bsio_ports
  import bsio_pkg::*;
#(
  parameter int unsigned PORT_W = BSIO_DW
) (
  input  wire logic                ref_clk,
  input  wire logic                reset_n,
  input  wire logic [BSIO_AW-1:0]  reg_addr,
  input  wire logic [BSIO_DW-1:0]  reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [BSIO_DW-1:0]  reg_rdata,
  input  wire bsio_ext_bus_s       ext_bus,
  output logic      [BSIO_XD-1:0]  ext_rdata,
  input  wire logic [PORT_W-1:0]   port_zero_in,
  output logic      [PORT_W-1:0]   port_zero_out,
  output logic      [PORT_W-1:0]   port_zero_oe,
  input  wire logic [PORT_W-1:0]   port_one_in,
  output logic      [PORT_W-1:0]   port_one_out,
  output logic      [PORT_W-1:0]   port_one_oe,
  input  wire logic [PORT_W-1:0]   port_two_in,
  output logic      [PORT_W-1:0]   port_two_out,
  output logic      [PORT_W-1:0]   port_two_oe
);

  // ==========================================================================
  // Helpers
  // Data read view: latch only where the pin is a plain output
  function automatic logic [PORT_W-1:0] read_view(
    input logic [PORT_W-1:0] pin,
    input logic [PORT_W-1:0] latch,
    input logic [PORT_W-1:0] dir,
    input logic [PORT_W-1:0] fn
  );
    read_view = (dir & ~fn & latch) | (~(dir & ~fn) & pin);
  endfunction : read_view

  function automatic logic hit(
    input logic [BSIO_AW-1:0] a,
    input logic [BSIO_AW-1:0] base
  );
    hit = (a == base);
  endfunction : hit

  // ==========================================================================
  // Registers
  logic [PORT_W-1:0]   zero_latch_q;
  logic [PORT_W-1:0]   zero_dir_q;
  logic [PORT_W-1:0]   one_latch_q;
  logic [PORT_W-1:0]   one_dir_q;
  logic [PORT_W-1:0]   one_fn_q;
  logic [PORT_W-1:0]   two_latch_q;
  logic [PORT_W-1:0]   two_dir_q;
  logic [PORT_W-1:0]   two_fn_q;
  logic [BSIO_DW-1:0]  rdata_q;
  logic [BSIO_DW-1:0]  rdata_d;
  logic [BSIO_XD-1:0]  ext_rdata_q;

  // ==========================================================================
  // Address decode
  wire logic wr_zero_data = reg_wr & hit(reg_addr, BSIO_PORT_ZERO_DATA_ADDR);
  wire logic wr_one_data  = reg_wr & hit(reg_addr, BSIO_PORT_ONE_DATA_ADDR);
  wire logic wr_two_data  = reg_wr & hit(reg_addr, BSIO_PORT_TWO_DATA_ADDR);
  wire logic wr_zero_dir  = reg_wr & hit(reg_addr, BSIO_PORT_ZERO_DIRECTION_ADDR);
  wire logic wr_one_dir   = reg_wr & hit(reg_addr, BSIO_PORT_ONE_DIRECTION_ADDR);
  wire logic wr_one_fn    = reg_wr & hit(reg_addr, BSIO_PORT_ONE_FUNCTION_ADDR);
  wire logic wr_two_dir   = reg_wr & hit(reg_addr, BSIO_PORT_TWO_DIRECTION_ADDR);
  wire logic wr_two_fn    = reg_wr & hit(reg_addr, BSIO_PORT_TWO_FUNCTION_ADDR);

  wire logic [PORT_W-1:0] wdata_w = reg_wdata[PORT_W-1:0];

  // ==========================================================================
  // Port zero registers
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      zero_latch_q <= BSIO_PORT_ZERO_LATCH_RST[PORT_W-1:0];
      zero_dir_q   <= BSIO_DIRECTION_RST[PORT_W-1:0];
    end else begin
      if (wr_zero_data) begin
        zero_latch_q <= wdata_w;
      end
      if (wr_zero_dir) begin
        zero_dir_q <= wdata_w;
      end
    end
  end

  // ==========================================================================
  // Port one registers
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      one_latch_q <= BSIO_PORT_ONE_LATCH_RST[PORT_W-1:0];
      one_dir_q   <= BSIO_DIRECTION_RST[PORT_W-1:0];
      one_fn_q    <= BSIO_FUNCTION_RST[PORT_W-1:0];
    end else begin
      if (wr_one_data) begin
        one_latch_q <= wdata_w;
      end
      if (wr_one_dir) begin
        one_dir_q <= wdata_w;
      end
      if (wr_one_fn) begin
        one_fn_q <= wdata_w;
      end
    end
  end

  // ==========================================================================
  // Port two registers
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      two_latch_q <= BSIO_PORT_TWO_LATCH_RST[PORT_W-1:0];
      two_dir_q   <= BSIO_DIRECTION_RST[PORT_W-1:0];
      two_fn_q    <= BSIO_FUNCTION_RST[PORT_W-1:0];
    end else begin
      if (wr_two_data) begin
        two_latch_q <= wdata_w;
      end
      if (wr_two_dir) begin
        two_dir_q <= wdata_w;
      end
      if (wr_two_fn) begin
        two_fn_q <= wdata_w;
      end
    end
  end

  // ==========================================================================
  // External bus byte lanes
  // Muxed lanes carry address in the address phase, write data after it;
  // on a read data phase they float so the memory can drive them.
  wire logic              bus_mux_drive = ext_bus.access & (ext_bus.addr_phase | ext_bus.write);
  wire logic [PORT_W-1:0] low_mux_val   = ext_bus.addr_phase ? ext_bus.addr[PORT_W-1:0]
                                                             : ext_bus.wdata[PORT_W-1:0];
  wire logic [PORT_W-1:0] up_mux_val    = ext_bus.addr_phase
                                          ? ext_bus.addr[BSIO_MID_BYTE_LSB +: PORT_W]
                                          : ext_bus.wdata[BSIO_MID_BYTE_LSB +: PORT_W];
  wire logic [PORT_W-1:0] mid_addr_val  = ext_bus.addr[BSIO_MID_BYTE_LSB +: PORT_W];
  wire logic [PORT_W-1:0] low_addr_val  = ext_bus.addr[PORT_W-1:0];
  wire logic [PORT_W-1:0] high_addr_val = ext_bus.addr[BSIO_HIGH_BYTE_LSB +: PORT_W];

  // ==========================================================================
  // Port zero pin drive
  // Bus takeover only while every direction bit is clear, so software
  // outputs never collide with the bus.
  wire logic zero_bus_mode = ext_bus.access & (zero_dir_q == '0);

  assign port_zero_out = zero_bus_mode ? low_mux_val : zero_latch_q;
  assign port_zero_oe  = zero_bus_mode ? {PORT_W{bus_mux_drive}} : zero_dir_q;

  // ==========================================================================
  // Port one and two per-pin role selection
  bsio_pin_drive_s one_drive;
  bsio_pin_drive_s two_drive;

  for (genvar i = 0; i < PORT_W; i++) begin : g_pin
    wire bsio_role_e one_role = bsio_role_e'({one_fn_q[i], one_dir_q[i]});
    wire bsio_role_e two_role = bsio_role_e'({two_fn_q[i], two_dir_q[i]});

    always_comb begin
      unique case (one_role)
        BSIO_ROLE_INPUT: begin
          one_drive.out[i] = one_latch_q[i];
          one_drive.oe[i]  = 1'b0;
        end
        BSIO_ROLE_OUTPUT: begin
          one_drive.out[i] = one_latch_q[i];
          one_drive.oe[i]  = 1'b1;
        end
        BSIO_ROLE_BUS_A: begin
          one_drive.out[i] = up_mux_val[i];
          one_drive.oe[i]  = bus_mux_drive;
        end
        BSIO_ROLE_BUS_B: begin
          one_drive.out[i] = mid_addr_val[i];
          one_drive.oe[i]  = 1'b1;
        end
      endcase
    end

    always_comb begin
      unique case (two_role)
        BSIO_ROLE_INPUT: begin
          two_drive.out[i] = two_latch_q[i];
          two_drive.oe[i]  = 1'b0;
        end
        BSIO_ROLE_OUTPUT: begin
          two_drive.out[i] = two_latch_q[i];
          two_drive.oe[i]  = 1'b1;
        end
        BSIO_ROLE_BUS_A: begin
          two_drive.out[i] = low_addr_val[i];
          two_drive.oe[i]  = 1'b1;
        end
        BSIO_ROLE_BUS_B: begin
          two_drive.out[i] = high_addr_val[i];
          two_drive.oe[i]  = 1'b1;
        end
      endcase
    end
  end

  assign port_one_out = one_drive.out;
  assign port_one_oe  = one_drive.oe;
  assign port_two_out = two_drive.out;
  assign port_two_oe  = two_drive.oe;

  // ==========================================================================
  // Read path
  // Direction and function registers are write-only and read as zero.
  wire logic [PORT_W-1:0] zero_view = read_view(port_zero_in, zero_latch_q, zero_dir_q, '0);
  wire logic [PORT_W-1:0] one_view  = read_view(port_one_in, one_latch_q, one_dir_q, one_fn_q);
  wire logic [PORT_W-1:0] two_view  = read_view(port_two_in, two_latch_q, two_dir_q, two_fn_q);

  always_comb begin
    rdata_d = BSIO_READ_NONE;
    if (reg_rd) begin
      if (hit(reg_addr, BSIO_PORT_ZERO_DATA_ADDR)) begin
        rdata_d[PORT_W-1:0] = zero_view;
      end else if (hit(reg_addr, BSIO_PORT_ONE_DATA_ADDR)) begin
        rdata_d[PORT_W-1:0] = one_view;
      end else if (hit(reg_addr, BSIO_PORT_TWO_DATA_ADDR)) begin
        rdata_d[PORT_W-1:0] = two_view;
      end
    end
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rdata_q <= BSIO_READ_NONE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ==========================================================================
  // External read data capture
  // Sampled every cycle; the memory controller picks the cycle it needs.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ext_rdata_q <= BSIO_EXT_RDATA_RST;
    end else begin
      ext_rdata_q <= {port_one_in, port_zero_in};
    end
  end

  assign ext_rdata = ext_rdata_q;

endmodule : bsio_ports

//--- verif/bsio_pin_load.sv
// Pin load model: resolves each pin from the port driver and an outside load
`timescale 1ns/1ns
module bsio_pin_load
  import bsio_pkg::*;
(
  input  wire logic [BSIO_DW-1:0] drv,
  input  wire logic [BSIO_DW-1:0] oe,
  input  wire logic [BSIO_DW-1:0] load,
  output logic      [BSIO_DW-1:0] pin
);
  // Released bits show the load, which the bench changes once per random round
  assign pin = (drv & oe) | (load & ~oe);
endmodule : bsio_pin_load

//--- verif/bsio_ports_monitor.sv
// Checker: pins and register port against a shadow of the registers
`timescale 1ns/1ns
module bsio_ports_monitor
  import bsio_pkg::*;
#(
  parameter int unsigned PORT_W = BSIO_DW
) (
  input wire logic               ref_clk,
  input wire logic               reset_n,
  input wire logic [BSIO_AW-1:0] reg_addr,
  input wire logic [BSIO_DW-1:0] reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [BSIO_DW-1:0] reg_rdata,
  input wire bsio_ext_bus_s      ext_bus,
  input wire logic [BSIO_XD-1:0] ext_rdata,
  input wire logic [PORT_W-1:0]  port_zero_in,
  input wire logic [PORT_W-1:0]  port_zero_out,
  input wire logic [PORT_W-1:0]  port_zero_oe,
  input wire logic [PORT_W-1:0]  port_one_in,
  input wire logic [PORT_W-1:0]  port_one_out,
  input wire logic [PORT_W-1:0]  port_one_oe,
  input wire logic [PORT_W-1:0]  port_two_in,
  input wire logic [PORT_W-1:0]  port_two_out,
  input wire logic [PORT_W-1:0]  port_two_oe
);
  // ======
  // Shadow, indexed by the low address bits
  logic [PORT_W-1:0] sh_q [32];
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < 32; i++) sh_q[i] <= (i == 18) ? BSIO_PORT_TWO_LATCH_RST : BSIO_DIRECTION_RST;
    end else if (reg_wr && reg_addr[31:5] == BSIO_PORT_ZERO_DATA_ADDR[31:5]) begin
      sh_q[reg_addr[4:0]] <= reg_wdata;
    end
  end
  wire [PORT_W-1:0] l0 = sh_q[0];
  wire [PORT_W-1:0] d0 = sh_q[2];
  wire [PORT_W-1:0] l1 = sh_q[1];
  wire [PORT_W-1:0] d1 = sh_q[4];
  wire [PORT_W-1:0] f1 = sh_q[5];
  wire [PORT_W-1:0] l2 = sh_q[18];
  wire [PORT_W-1:0] d2 = sh_q[20];
  wire [PORT_W-1:0] f2 = sh_q[21];
  wire              ph = ext_bus.access & (ext_bus.addr_phase | ext_bus.write);
  wire              own = ext_bus.access & (d0 == '0);
  wire [15:0]       mx = ext_bus.addr_phase ? ext_bus.addr[15:0] : ext_bus.wdata;
  wire [PORT_W-1:0] oe1 = d1 | (f1 & {PORT_W{ph}});
  wire [PORT_W-1:0] o1 = (d1 & ~f1 & l1) | (d1 & f1 & ext_bus.addr[15:8]) | (~d1 & f1 & mx[15:8]);
  wire [PORT_W-1:0] oe2 = d2 | f2;
  wire [PORT_W-1:0] o2 = (~f2 & l2) | (f2 & ~d2 & ext_bus.addr[7:0]) | (f2 & d2 & ext_bus.addr[23:16]);
  logic [PORT_W-1:0] rx;
  always_comb begin
    case (reg_addr)
      BSIO_PORT_ZERO_DATA_ADDR: rx = (l0 & d0) | (port_zero_in & ~d0);
      BSIO_PORT_ONE_DATA_ADDR:  rx = (l1 & d1 & ~f1) | (port_one_in & ~(d1 & ~f1));
      BSIO_PORT_TWO_DATA_ADDR:  rx = (l2 & d2 & ~f2) | (port_two_in & ~(d2 & ~f2));
      default:                  rx = BSIO_READ_NONE;
    endcase
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == BSIO_READ_NONE)
    else $error("read data not zero outside a read");
  a_read_value: assert property (reg_rd |=> reg_rdata == $past(rx))
    else $error("read data wrong");
  a_ext_sample: assert property (1'b1 |=> ext_rdata == {$past(port_one_in), $past(port_zero_in)})
    else $error("external read data wrong");
  a_zero_gpio: assert property (!own |-> port_zero_oe == d0 && ((port_zero_out ^ l0) & d0) == '0)
    else $error("port zero general purpose drive wrong");
  a_zero_bus: assert property (own |-> port_zero_oe == {PORT_W{ph}} && (!ph || port_zero_out == mx[7:0]))
    else $error("port zero bus drive wrong");
  a_one_enable: assert property (port_one_oe == oe1)
    else $error("port one enable wrong");
  a_one_value: assert property (((port_one_out ^ o1) & oe1) == '0)
    else $error("port one value wrong");
  a_two_roles: assert property (port_two_oe == oe2 && ((port_two_out ^ o2) & oe2) == '0)
    else $error("port two drive wrong");
endmodule : bsio_ports_monitor

//--- verif/bsio_ports_test.sv
// Testbench: register, pin role and external bus scenarios for the ports
`timescale 1ns/1ns
module bsio_ports_test
  import bsio_pkg::*;
;
  logic               ref_clk, reset_n, reg_wr, reg_rd;
  logic [BSIO_AW-1:0] reg_addr;
  logic [BSIO_DW-1:0] reg_wdata, reg_rdata, rv;
  logic [BSIO_XD-1:0] ext_rdata, e;
  bsio_ext_bus_s      ext_bus;
  logic [7:0]         p0_in, p0_out, p0_oe, p1_in, p1_out, p1_oe, p2_in, p2_out, p2_oe, ld0, ld1, ld2;
  logic [7:0]         sh [32];
  int                 failures, total_checks;
  logic [31:0]        regs [8] = '{BSIO_PORT_ZERO_DATA_ADDR, BSIO_PORT_ONE_DATA_ADDR, BSIO_PORT_ZERO_DIRECTION_ADDR,
    BSIO_PORT_ONE_DIRECTION_ADDR, BSIO_PORT_ONE_FUNCTION_ADDR, BSIO_PORT_TWO_DATA_ADDR,
    BSIO_PORT_TWO_DIRECTION_ADDR, BSIO_PORT_TWO_FUNCTION_ADDR};

  bsio_ports i_bsio_ports (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_bus(ext_bus), .ext_rdata(ext_rdata),
    .port_zero_in(p0_in), .port_zero_out(p0_out), .port_zero_oe(p0_oe), .port_one_in(p1_in),
    .port_one_out(p1_out), .port_one_oe(p1_oe), .port_two_in(p2_in), .port_two_out(p2_out), .port_two_oe(p2_oe));
  bsio_pin_load i_bsio_pin_load_0 (.drv(p0_out), .oe(p0_oe), .load(ld0), .pin(p0_in));
  bsio_pin_load i_bsio_pin_load_1 (.drv(p1_out), .oe(p1_oe), .load(ld1), .pin(p1_in));
  bsio_pin_load i_bsio_pin_load_2 (.drv(p2_out), .oe(p2_oe), .load(ld2), .pin(p2_in));

  // ======
  // Tasks
  function automatic logic [7:0] mix(input logic [7:0] a, input logic [7:0] b, input logic [7:0] m);
    mix = (a & m) | (b & ~m);
  endfunction : mix
  task automatic chk(input logic [15:0] x, input logic [15:0] g);
    total_checks++;
    if (g !== x) begin
      failures++;
      $display("FAIL t=%0t exp=%h got=%h", $time, x, g);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    sh[a[4:0]] = d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    rv = reg_rdata;
  endtask : rd
  task automatic do_reset();
    @(posedge ref_clk);
    reset_n <= 1'b0;
    foreach (sh[i]) sh[i] = (i == 18) ? 8'hFF : 8'h00;
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
  endtask : do_reset
  // No bus access here; address roles still drive
  task automatic check_gpio();
    logic [7:0] o1, o2, e2;
    @(negedge ref_clk);
    o1 = mix(ext_bus.addr[15:8], sh[1], sh[5]);
    o2 = mix(mix(ext_bus.addr[23:16], ext_bus.addr[7:0], sh[20]), sh[18], sh[21]);
    e2 = sh[20] | sh[21];
    chk(sh[2], p0_oe);
    chk(sh[2] & sh[0], p0_out & sh[2]);
    chk(sh[4], p1_oe);
    chk(o1 & sh[4], p1_out & sh[4]);
    chk(e2, p2_oe);
    chk(o2 & e2, p2_out & e2);
    rd(regs[0]);
    chk(mix(sh[0], ld0, sh[2]), rv);
    rd(regs[1]);
    chk(mix(sh[1], mix(o1, ld1, sh[4]), sh[4] & ~sh[5]), rv);
    rd(regs[5]);
    chk(mix(sh[18], mix(o2, ld2, e2), sh[20] & ~sh[21]), rv);
  endtask : check_gpio

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    results();
  end

  // ======
  // Main sequence
  initial begin
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    ext_bus = '0;
    {ld0, ld1, ld2} = 24'hC3A55A;
    failures = 0;
    total_checks = 0;
    void'($urandom(24));
    do_reset();
    check_gpio();
    // Write-only and unmapped places read as zero
    foreach (regs[k]) begin
      rd(k inside {0, 1, 5} ? 32'hFFFFF003 : regs[k]);
      chk(16'h0000, rv);
    end
    // Every role code; code 01 first shows the latch reset values
    for (int r = 1; r < 5; r++) begin
      wr(regs[3], {8{r[0]}});
      wr(regs[4], {8{r[1]}});
      wr(regs[6], {8{r[0]}});
      wr(regs[7], {8{r[1]}});
      wr(regs[2], {8{r[0]}});
      check_gpio();
    end
    repeat (40) begin
      @(posedge ref_clk);
      ld0 <= 8'($urandom);
      ld1 <= 8'($urandom);
      ld2 <= 8'($urandom);
      ext_bus.addr <= 24'($urandom);
      foreach (regs[k]) if ($urandom_range(1)) wr(regs[k], 8'($urandom));
      check_gpio();
    end
    do_reset();
    check_gpio();
    // External access: port one muxed, port zero direction clear
    wr(regs[4], 8'hFF);
    for (int ph = 0; ph < 3; ph++) begin
      @(posedge ref_clk);
      ext_bus <= '{access: 1'b1, addr_phase: (ph == 0), write: (ph == 1), addr: 24'($urandom), wdata: 16'($urandom)};
      @(negedge ref_clk);
      e = (ph == 0) ? ext_bus.addr[15:0] : ext_bus.wdata;
      chk((ph == 2) ? 16'h0000 : 16'hFFFF, {p1_oe, p0_oe});
      if (ph != 2) chk(e, {p1_out, p0_out});
    end
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk({ld1, ld0}, ext_rdata);
    // Any direction bit set keeps port zero general purpose
    wr(regs[2], 8'h5A);
    @(negedge ref_clk);
    chk(16'h005A, {8'h00, p0_oe});
    results();
  end
endmodule : bsio_ports_test

bind bsio_ports bsio_ports_monitor #(.PORT_W(PORT_W)) i_bsio_ports_monitor (.ref_clk(ref_clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ext_bus(ext_bus), .ext_rdata(ext_rdata), .port_zero_in(port_zero_in), .port_zero_out(port_zero_out),
  .port_zero_oe(port_zero_oe), .port_one_in(port_one_in), .port_one_out(port_one_out), .port_one_oe(port_one_oe),
  .port_two_in(port_two_in), .port_two_out(port_two_out), .port_two_oe(port_two_oe));
